// [design/dac_cmp_consts.svh]
`ifndef DAC_CMP_CONSTS_SVH
`define DAC_CMP_CONSTS_SVH

// Register byte offsets (word aligned)
`define REG_CTRL       6'h00
`define REG_DAC_A      6'h04
`define REG_DAC_B      6'h08
`define REG_CMP_A      6'h0C
`define REG_CMP_B      6'h10
`define REG_STATUS     6'h14
`define REG_MASK       6'h18
`define REG_LEVEL      6'h1C

// Control register fields
`define CTRL_DAC_A_ON  0
`define CTRL_DAC_B_ON  1
`define CTRL_BUF_A_ON  2
`define CTRL_BUF_B_ON  3
`define CTRL_DAC_STOP  4
`define CTRL_CMP_STOP  5
`define CTRL_SYNC_UPD  6
`define CTRL_WAKE_A    8
`define CTRL_WAKE_B    9
`define CTRL_RESET     10'h030

// Comparator config fields
`define CMPF_PLUS_LO   0
`define CMPF_MINUS_LO  2
`define CMPF_SPEED     5
`define CMPF_DEADBAND  6
`define CMPF_ON        7
`define CMPF_ROUTE_PIN 8
`define CMPF_ROUTE_TMR 9
`define CMPF_WIDTH     10

// Safe select codes
`define PLUS_FIRST     2'h1
`define MINUS_FIRST    3'h1
`define CMP_RESET      10'h005

// Converter code width and full scale divisor
`define DAC_BITS       10
`define DAC_FULL_SCALE 1024

// Status / event bit positions
`define EV_A_RISE      0
`define EV_B_RISE      1
`define EV_A_FALL      2
`define EV_B_FALL      3
`define EV_BITS        4

`endif

// [design/dac_cmp_pkg.sv]
package dac_cmp_pkg;
  // Converter code
  typedef logic [9:0] dac_code_t;
  // Comparator plus select
  typedef logic [1:0] plus_sel_t;
  // Comparator minus select
  typedef logic [2:0] minus_sel_t;
  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage

// [design/cmp_result_sync.sv]
`timescale 1ns/1ns
// Two-flop synchroniser with edge detection on the settled copy
module cmp_result_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Raw comparator level
  input  wire logic rawIn,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic stage1;   // Only read by stage two
  logic stage2;   // Settled copy
  logic stage3;   // Previous settled value

  // Shift chain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edge pulses from settled copies only
  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;
endmodule

// [design/cmp_select_guard.sv]
`timescale 1ns/1ns
`include "dac_cmp_consts.svh"
// Replaces illegal all-zero select codes with the first source
module cmp_select_guard
  import dac_cmp_pkg::*;
(
  // Requested codes
  input  wire dac_cmp_pkg::plus_sel_t  plusIn,
  input  wire dac_cmp_pkg::minus_sel_t minusIn,
  // Guarded codes
  output dac_cmp_pkg::plus_sel_t       plusOut,
  output dac_cmp_pkg::minus_sel_t      minusOut
);
  // Plus code 11 is also undefined; fall back to first source
  assign plusOut  = (plusIn == 2'h0 || plusIn == 2'h3) ? `PLUS_FIRST : plusIn;
  assign minusOut = (minusIn == 3'h0) ? `MINUS_FIRST : minusIn;
endmodule

// [design/dac_comparator_control.sv]
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "dac_cmp_consts.svh"
module dac_comparator_control
  import dac_cmp_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [5:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // Converter macro pins
  output logic                        dac_a_on_n,
  output logic                        dac_b_on_n,
  output logic                        dac_a_buf_on_n,
  output logic                        dac_b_buf_on_n,
  output logic                        dac_stop,
  output dac_cmp_pkg::dac_code_t      dac_a_code,
  output dac_cmp_pkg::dac_code_t      dac_b_code,
  // External simultaneous update trigger
  input  wire logic                   dacTrigger,
  // Comparator macro pins
  output dac_cmp_pkg::plus_sel_t      cmp_a_plus_select,
  output dac_cmp_pkg::plus_sel_t      cmp_b_plus_select,
  output dac_cmp_pkg::minus_sel_t     cmp_a_minus_select,
  output dac_cmp_pkg::minus_sel_t     cmp_b_minus_select,
  output logic                        cmp_a_speed_select,
  output logic                        cmp_b_speed_select,
  output logic                        cmp_a_deadband_on,
  output logic                        cmp_b_deadband_on,
  output logic                        cmp_a_on_n,
  output logic                        cmp_b_on_n,
  output logic                        cmp_stop,
  input  wire logic                   cmp_a_result,
  input  wire logic                   cmp_b_result,
  // Routed results
  output logic                        cmpAPin,
  output logic                        cmpBPin,
  output logic                        cmpATimer,
  output logic                        cmpBTimer,
  // Wake and interrupt
  output logic                        wakeRequest,
  output logic                        irq
);
  import dac_cmp_pkg::*;

  // Software registers
  logic [9:0]            ctrl;        // Enables, stops, update mode, wake enables
  dac_code_t             dacAStage;   // Staged code, converter A
  dac_code_t             dacBStage;   // Staged code, converter B
  logic [`CMPF_WIDTH-1:0] cmpACfg;    // Comparator A configuration
  logic [`CMPF_WIDTH-1:0] cmpBCfg;    // Comparator B configuration
  logic [`EV_BITS-1:0]   status;      // Sticky edge events
  logic [`EV_BITS-1:0]   mask;        // Interrupt mask, 1 passes

  // Bus handshake
  bus_state_t            busState;
  logic                  access;      // New request this cycle
  logic                  wrAccess;    // Write taken this cycle
  logic [31:0]           wrMask;      // Byte lanes as bit mask
  logic [31:0]           next_rdData; // Read mux

  // Synchronised comparator levels and edges
  logic                  levelA;
  logic                  levelB;
  logic                  riseA;
  logic                  riseB;
  logic                  fallA;
  logic                  fallB;
  logic [`EV_BITS-1:0]   events;

  // Guarded select codes
  plus_sel_t             plusA;
  plus_sel_t             plusB;
  minus_sel_t            minusA;
  minus_sel_t            minusB;

  // Converter update strobes
  logic                  loadA;
  logic                  loadB;

  // Request taken only from idle, so each request acks once
  assign access   = wb_cyc_i & wb_stb_i & (busState == BUS_IDLE);
  assign wrAccess = access & wb_we_i;
  assign wrMask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Slave state: ack one cycle after request, then a gap
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busState <= BUS_IDLE;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          if (access) begin
            busState <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState <= BUS_IDLE;
        end
        default: begin
          busState <= BUS_IDLE;
        end
      endcase
    end
  end

  // Ack marks the answer cycle
  assign wb_ack_o = (busState == BUS_ACK);

  // Control register write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RESET;
    end else if (wrAccess && wb_adr_i == `REG_CTRL) begin
      ctrl <= (ctrl & ~wrMask[9:0]) | (wb_dat_i[9:0] & wrMask[9:0]);
    end
  end

  // Staged converter codes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dacAStage <= '0;
      dacBStage <= '0;
    end else if (wrAccess) begin
      if (wb_adr_i == `REG_DAC_A) begin
        dacAStage <= (dacAStage & ~wrMask[9:0]) | (wb_dat_i[9:0] & wrMask[9:0]);
      end
      if (wb_adr_i == `REG_DAC_B) begin
        dacBStage <= (dacBStage & ~wrMask[9:0]) | (wb_dat_i[9:0] & wrMask[9:0]);
      end
    end
  end

  // Comparator configuration, safe codes after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmpACfg <= `CMP_RESET;
      cmpBCfg <= `CMP_RESET;
    end else if (wrAccess) begin
      if (wb_adr_i == `REG_CMP_A) begin
        cmpACfg <= (cmpACfg & ~wrMask[9:0]) | (wb_dat_i[9:0] & wrMask[9:0]);
      end
      if (wb_adr_i == `REG_CMP_B) begin
        cmpBCfg <= (cmpBCfg & ~wrMask[9:0]) | (wb_dat_i[9:0] & wrMask[9:0]);
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask <= '0;
    end else if (wrAccess && wb_adr_i == `REG_MASK && wb_sel_i[0]) begin
      mask <= wb_dat_i[`EV_BITS-1:0];
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status <= '0;
    end else if (wrAccess && wb_adr_i == `REG_STATUS && wb_sel_i[0]) begin
      status <= (status & ~wb_dat_i[`EV_BITS-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  // Read mux; unmapped offsets read zero but still ack
  always_comb begin
    next_rdData = 32'h0000_0000;
    unique case (wb_adr_i)
      `REG_CTRL:   next_rdData[9:0] = ctrl;
      `REG_DAC_A:  next_rdData[9:0] = dacAStage;
      `REG_DAC_B:  next_rdData[9:0] = dacBStage;
      `REG_CMP_A:  next_rdData[9:0] = cmpACfg;
      `REG_CMP_B:  next_rdData[9:0] = cmpBCfg;
      `REG_STATUS: next_rdData[`EV_BITS-1:0] = status;
      `REG_MASK:   next_rdData[`EV_BITS-1:0] = mask;
      `REG_LEVEL:  next_rdData[1:0] = {levelB, levelA};
      default:     next_rdData = 32'h0000_0000;
    endcase
  end

  // Read data captured with the request, valid during ack
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access) begin
      wb_dat_o <= next_rdData;
    end
  end

  // Converter load: immediate per channel, or both on trigger
  assign loadA = ctrl[`CTRL_SYNC_UPD] ? dacTrigger : 1'b1;
  assign loadB = ctrl[`CTRL_SYNC_UPD] ? dacTrigger : 1'b1;

  // Converter codes held in flops; analog scale is code/1024
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dac_a_code <= '0;
      dac_b_code <= '0;
    end else begin
      if (loadA) begin
        dac_a_code <= dacAStage;
      end
      if (loadB) begin
        dac_b_code <= dacBStage;
      end
    end
  end

  // Converter enables, inverted to active low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dac_a_on_n     <= 1'b1;
      dac_b_on_n     <= 1'b1;
      dac_a_buf_on_n <= 1'b1;
      dac_b_buf_on_n <= 1'b1;
      dac_stop       <= 1'b1;
    end else begin
      dac_a_on_n     <= ~ctrl[`CTRL_DAC_A_ON];
      dac_b_on_n     <= ~ctrl[`CTRL_DAC_B_ON];
      dac_a_buf_on_n <= ~ctrl[`CTRL_BUF_A_ON];
      dac_b_buf_on_n <= ~ctrl[`CTRL_BUF_B_ON];
      dac_stop       <= ctrl[`CTRL_DAC_STOP];
    end
  end

  // Keep select codes legal whatever software wrote
  cmp_select_guard guardA (
    .plusIn   (cmpACfg[`CMPF_PLUS_LO +: 2]),
    .minusIn  (cmpACfg[`CMPF_MINUS_LO +: 3]),
    .plusOut  (plusA),
    .minusOut (minusA)
  );

  cmp_select_guard guardB (
    .plusIn   (cmpBCfg[`CMPF_PLUS_LO +: 2]),
    .minusIn  (cmpBCfg[`CMPF_MINUS_LO +: 3]),
    .plusOut  (plusB),
    .minusOut (minusB)
  );

  // Comparator macro controls, all registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmp_a_plus_select  <= `PLUS_FIRST;
      cmp_b_plus_select  <= `PLUS_FIRST;
      cmp_a_minus_select <= `MINUS_FIRST;
      cmp_b_minus_select <= `MINUS_FIRST;
      cmp_a_speed_select <= 1'b0;
      cmp_b_speed_select <= 1'b0;
      cmp_a_deadband_on  <= 1'b0;
      cmp_b_deadband_on  <= 1'b0;
      cmp_a_on_n         <= 1'b1;
      cmp_b_on_n         <= 1'b1;
      cmp_stop           <= 1'b1;
    end else begin
      cmp_a_plus_select  <= plusA;
      cmp_b_plus_select  <= plusB;
      cmp_a_minus_select <= minusA;
      cmp_b_minus_select <= minusB;
      cmp_a_speed_select <= cmpACfg[`CMPF_SPEED];
      cmp_b_speed_select <= cmpBCfg[`CMPF_SPEED];
      cmp_a_deadband_on  <= cmpACfg[`CMPF_DEADBAND];
      cmp_b_deadband_on  <= cmpBCfg[`CMPF_DEADBAND];
      cmp_a_on_n         <= ~cmpACfg[`CMPF_ON];
      cmp_b_on_n         <= ~cmpBCfg[`CMPF_ON];
      cmp_stop           <= ctrl[`CTRL_CMP_STOP];
    end
  end

  // Results are asynchronous to clk; sync before any use
  cmp_result_sync syncA (
    .clk   (clk),
    .rst_b (rst_b),
    .rawIn (cmp_a_result),
    .level (levelA),
    .rise  (riseA),
    .fall  (fallA)
  );

  cmp_result_sync syncB (
    .clk   (clk),
    .rst_b (rst_b),
    .rawIn (cmp_b_result),
    .level (levelB),
    .rise  (riseB),
    .fall  (fallB)
  );

  // Events only count while the comparator is powered
  assign events = {fallB & ~cmp_b_on_n, fallA & ~cmp_a_on_n,
                   riseB & ~cmp_b_on_n, riseA & ~cmp_a_on_n};

  // Routing to pin and timers, gated by route enables
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmpAPin   <= 1'b0;
      cmpBPin   <= 1'b0;
      cmpATimer <= 1'b0;
      cmpBTimer <= 1'b0;
    end else begin
      cmpAPin   <= levelA & cmpACfg[`CMPF_ROUTE_PIN];
      cmpBPin   <= levelB & cmpBCfg[`CMPF_ROUTE_PIN];
      cmpATimer <= levelA & cmpACfg[`CMPF_ROUTE_TMR];
      cmpBTimer <= levelB & cmpBCfg[`CMPF_ROUTE_TMR];
    end
  end

  // Wake request: level, held high while the result stays high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= (levelA & ctrl[`CTRL_WAKE_A] & ~cmp_a_on_n) |
                     (levelB & ctrl[`CTRL_WAKE_B] & ~cmp_b_on_n);
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(status & mask);
endmodule

// [verif/dac_comparator_control_properties.sv]
`timescale 1ns/1ns
// Pin and bus-handshake checks for the converter/comparator control
module dac_comparator_control_properties
  import dac_cmp_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_b,
  // Bus side
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [5:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // Macro pins
  input wire logic          dac_a_on_n,
  input wire logic          dac_stop,
  input wire plus_sel_t     cmp_a_plus_select,
  input wire minus_sel_t    cmp_a_minus_select,
  input wire logic          cmp_a_speed_select,
  input wire logic          cmp_a_deadband_on,
  input wire logic          cmp_a_on_n,
  input wire logic          cmp_stop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Answer exactly one cycle after the request is taken
  property p_ack_answer; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack not one cycle after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  // Offsets from 0x20 upward read back zero
  property p_unmapped_zero; wb_ack_o && !wb_we_i && wb_adr_i >= 6'h20 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_plus_legal; cmp_a_plus_select inside {2'h1, 2'h2}; endproperty
  a_plus_legal: assert property (p_plus_legal) else $error("plus select illegal");
  property p_minus_legal; cmp_a_minus_select != 3'h0; endproperty
  a_minus_legal: assert property (p_minus_legal) else $error("minus select zero");
  // Leaving reset converter A and comparator A are off and both are stopped
  property p_reset_safe; $rose(rst_b) |-> dac_a_on_n && cmp_a_on_n && dac_stop && cmp_stop;
  endproperty
  a_reset_safe: assert property (p_reset_safe) else $error("not safe after reset");
  // Control write reaches the pins, inverted for enables
  property p_ctrl_enable;
    $rose(wb_cyc_i && wb_stb_i) && wb_we_i && wb_adr_i == 6'h00 && wb_sel_i[0] |->
      ##3 dac_a_on_n == !$past(wb_dat_i[0], 3) && dac_stop == $past(wb_dat_i[4], 3);
  endproperty
  a_ctrl_enable: assert property (p_ctrl_enable) else $error("control pins wrong");
  property p_cmp_cfg;
    $rose(wb_cyc_i && wb_stb_i) && wb_we_i && wb_adr_i == 6'h0C && wb_sel_i[0] |->
      ##3 cmp_a_speed_select == $past(wb_dat_i[5], 3)
      && cmp_a_deadband_on == $past(wb_dat_i[6], 3);
  endproperty
  a_cmp_cfg: assert property (p_cmp_cfg) else $error("speed or deadband wrong");
endmodule

bind dac_comparator_control dac_comparator_control_properties u_props (.clk, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .dac_a_on_n, .dac_stop, .cmp_a_plus_select, .cmp_a_minus_select, .cmp_a_speed_select,
  .cmp_a_deadband_on, .cmp_a_on_n, .cmp_stop);

// [verif/analog_macro_model.sv]
`timescale 1ns/1ns
// Converter and comparator macros; levels in steps of ref/1024
module analog_macro_model
  import dac_cmp_pkg::*;
(
  // Converter A
  input  wire dac_code_t     dac_a_code,
  input  wire logic          dac_a_on_n,
  input  wire logic          dac_stop,
  // Comparator controls
  input  wire plus_sel_t     cmp_a_plus_select,
  input  wire plus_sel_t     cmp_b_plus_select,
  input  wire minus_sel_t    cmp_a_minus_select,
  input  wire minus_sel_t    cmp_b_minus_select,
  input  wire logic          cmp_a_on_n,
  input  wire logic          cmp_b_on_n,
  input  wire logic          cmp_stop,
  // Plus candidate levels
  input  wire logic [9:0]    srcFirst,
  input  wire logic [9:0]    srcSecond,
  // Comparator outputs
  output logic               cmp_a_result,
  output logic               cmp_b_result
);
  int dacOut;  // Converter level, zero when off
  function automatic int plusLvl(input plus_sel_t p);
    return (p == 2'h2) ? srcSecond : srcFirst;
  endfunction
  // Lower codes see the converter, upper codes quarter steps of ref
  function automatic int minusLvl(input minus_sel_t m);
    return m[2] ? 256 * (m[1:0] + 1) : dacOut;
  endfunction
  // Disabled or stopped parts give nothing
  always_comb begin
    dacOut = (dac_a_on_n || dac_stop) ? 0 : 1024 * dac_a_code / 1024;
    cmp_a_result = !cmp_a_on_n && !cmp_stop
      && plusLvl(cmp_a_plus_select) > minusLvl(cmp_a_minus_select);
    cmp_b_result = !cmp_b_on_n && !cmp_stop
      && plusLvl(cmp_b_plus_select) > minusLvl(cmp_b_minus_select);
  end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ns
// Random and corner stimulus for the converter/comparator control
module testbench;
  import dac_cmp_pkg::*;
  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dacTrigger;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic        dac_a_on_n, dac_b_on_n, dac_a_buf_on_n, dac_b_buf_on_n, dac_stop;
  dac_code_t   dac_a_code, dac_b_code, codeA, codeB;
  plus_sel_t   cmp_a_plus_select, cmp_b_plus_select;
  minus_sel_t  cmp_a_minus_select, cmp_b_minus_select;
  logic        cmp_a_speed_select, cmp_b_speed_select, cmp_a_deadband_on, cmp_b_deadband_on;
  logic        cmp_a_on_n, cmp_b_on_n, cmp_stop, cmp_a_result, cmp_b_result;
  logic        cmpAPin, cmpBPin, cmpATimer, cmpBTimer, wakeRequest, irq;
  logic [9:0]  srcFirst, srcSecond;
  logic [4:0]  i;
  int          miscompares, compares;

  dac_comparator_control u_dac_comparator_control (.*);
  analog_macro_model u_analog_macro_model (.*);

  // System clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Illegal codes reach the pins as the first source
  function automatic plus_sel_t plusExp(input plus_sel_t p);
    return (p == 2'h0 || p == 2'h3) ? 2'h1 : p;
  endfunction
  function automatic minus_sel_t minusExp(input minus_sel_t m);
    return (m == 3'h0) ? 3'h1 : m;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One classic cycle; bounded wait for ack
  task bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hF;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      close_out();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Let the pin registers take the written value
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, dacTrigger} = 5'h00;
    {wb_adr_i, wb_dat_i, srcFirst, srcSecond} = '0;
    wb_sel_i = 4'hF;
    seed = 32'hFECC;
    miscompares = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({dac_a_on_n, dac_b_on_n, dac_a_buf_on_n, dac_b_buf_on_n, dac_stop}, 5'h1F);
    chk({cmp_a_on_n, cmp_b_on_n, cmp_stop, dac_a_code}, 13'h1C00);
    chk({cmp_a_plus_select, cmp_a_minus_select, cmp_b_plus_select, cmp_b_minus_select},
        10'h129);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      bus(1'b1, 6'h00, {22'h000000, seed[9:0]});
      settle;
      chk({dac_a_on_n, dac_b_on_n, dac_a_buf_on_n, dac_b_buf_on_n},
          {~seed[0], ~seed[1], ~seed[2], ~seed[3]});
      chk({dac_stop, cmp_stop}, {seed[4], seed[5]});
    end
    // Immediate update, then held codes until the trigger
    codeA = seed[25:16];
    codeB = seed[19:10];
    bus(1'b1, 6'h00, 32'h0000000F);
    bus(1'b1, 6'h04, {22'h000000, codeA});
    bus(1'b1, 6'h08, {22'h000000, codeB});
    settle;
    chk({dac_a_code, dac_b_code, dac_a_on_n, dac_stop}, {codeA, codeB, 2'h0});
    bus(1'b1, 6'h00, 32'h0000004F);
    bus(1'b1, 6'h04, {22'h000000, ~codeA});
    bus(1'b1, 6'h08, 32'h000003FF);
    settle;
    chk({dac_a_code, dac_b_code}, {codeA, codeB});
    @(posedge clk);
    dacTrigger <= 1'b1;
    @(posedge clk);
    dacTrigger <= 1'b0;
    settle;
    chk({dac_a_code, dac_b_code}, {~codeA, 10'h3FF});
    $display("converter test done");
    // Every select code, random speed and deadband
    for (int k = 0; k < 32; k++) begin
      i = k[4:0];
      seed = xs(seed);
      bus(1'b1, 6'h0C, {25'h0000000, seed[1:0], i});
      bus(1'b1, 6'h10, {25'h0000000, seed[3:2], ~i});
      settle;
      chk({cmp_a_plus_select, cmp_a_minus_select}, {plusExp(i[1:0]), minusExp(i[4:2])});
      chk({cmp_b_plus_select, cmp_b_minus_select}, {plusExp(~i[1:0]), minusExp(~i[4:2])});
      chk({cmp_a_speed_select, cmp_a_deadband_on, cmp_b_speed_select, cmp_b_deadband_on},
          {seed[0], seed[1], seed[2], seed[3]});
    end
    $display("select test done");
    // Rise above half reference: route, wake and masked interrupt
    @(posedge clk);
    srcFirst <= 10'h2BC;
    bus(1'b1, 6'h00, 32'h00000100);
    bus(1'b1, 6'h18, 32'h00000001);
    bus(1'b1, 6'h0C, 32'h00000395);
    repeat (6) @(posedge clk);
    #1;
    chk({cmp_a_on_n, cmpAPin, cmpATimer, wakeRequest, irq, cmpBPin, cmpBTimer}, 7'h3C);
    bus(1'b0, 6'h14, 32'h0);
    chk(rd[3:0], 4'h1);
    bus(1'b0, 6'h1C, 32'h0);
    chk(rd[1:0], 2'h1);
    bus(1'b1, 6'h18, 32'h0);
    settle;
    chk(irq, 1'b0);
    bus(1'b1, 6'h18, 32'h00000005);
    bus(1'b1, 6'h14, 32'h00000001);
    settle;
    chk(irq, 1'b0);
    @(posedge clk);
    srcFirst <= 10'h100;
    repeat (6) @(posedge clk);
    #1;
    chk({cmpAPin, cmpATimer, wakeRequest, irq}, 4'h1);
    bus(1'b0, 6'h14, 32'h0);
    chk(rd[3:0], 4'h4);
    bus(1'b1, 6'h24, 32'hFFFFFFFF);
    bus(1'b0, 6'h24, 32'h0);
    chk(rd, 32'h0);
    $display("comparator test done");
    close_out();
  end
endmodule
